// [design/rwc_consts.vh]
`ifndef RWC_CONSTS_VH
`define RWC_CONSTS_VH

// ****************************************
// Register map, byte addresses
// ****************************************
`define RWC_ADDR_MISC 4'h0
`define RWC_ADDR_STAT 4'h4
`define RWC_RESP_OKAY 2'h0
`define RWC_RESP_SLVERR 2'h2

// ****************************************
// Miscellaneous register fields
// ****************************************
`define RWC_MISC_POR 7
`define RWC_MISC_EIE 4
`define RWC_MISC_SLOW 1
`define RWC_MISC_WDE 0

// ****************************************
// Status register fields
// ****************************************
`define RWC_STAT_WCNT_LO 0
`define RWC_STAT_WCNT_HI 2
`define RWC_STAT_STOP 3
`define RWC_STAT_WAIT 4
`define RWC_STAT_MASK 5
`define RWC_STAT_WDRST 6
`define RWC_STAT_EXTRST 7

// ****************************************
// Reset values seen by other blocks
// ****************************************
`define RWC_TMR_RESET 16'hfffc
`define RWC_SP_RESET 16'h00ff

// ****************************************
// Timing
// ****************************************
`define RWC_CLK_MHZ 125
`define RWC_EXT_LOW_MACHINE_CYCLE_TIME_X10 15
`define RWC_EXT_LOW_CYC ((`RWC_EXT_LOW_MACHINE_CYCLE_TIME_X10 + 9) / 10)
`define RWC_WATCHDOG_ENABLE_CLEAR_BIT_LOW_NS 1000
`define RWC_WATCHDOG_ENABLE_CLEAR_BIT_LOW_CYC ((`RWC_WATCHDOG_ENABLE_CLEAR_BIT_LOW_NS * `RWC_CLK_MHZ + 999) / 1000)
`define RWC_POR_SHORT_CYC 12'h010
`define RWC_POR_LONG_CYC 12'hfe0
`define RWC_OSC_DELAY_CYC 12'hfe0

// ****************************************
// Watchdog chain
// ****************************************
`define RWC_DIV4_LAST 2'h3
`define RWC_DIV256_LAST 8'hff
`define RWC_DIV7_FINAL 3'h7

`endif

// [design/rwc_sync.v]
`timescale 1ns/1ps

// ****************************************
// Three-stage pin synchroniser
// ****************************************
module rwc_sync (
    input wire aclk, // Bus clock
    input wire aresetn, // Synchronous reset, active low
    input wire din, // Asynchronous pin level
    output reg level_q // Filtered level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // Level only moves once the last two stages agree, so a single
    // sampled glitch never reaches the reset logic
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule // rwc_sync

// [design/rwc_top.v]
// Overview of operation
// - Reset pin low for 1.5 machine cycles resets the device.
// - Pin back high: operation resumes on the next machine cycle.
// - Power-on or watchdog reset drives the reset pin low, open drain.
// - Watchdog chain: divide by 4, divide by 256, clearable divide by 7.
// - Chain is clocked by the timer bit 7 carry.
// - Watchdog enabled by mask option after reset, or by software writing 1.
// - Writing zero never disables an enabled watchdog.
// - Each write of 1 clears the divide-by-7 counter.
// - After watchdog reset the enable bit follows the mask option.
// - Seven counter clocks after clear or enable, a chip reset fires.
// - Watchdog drives pin, releases after pin low for minimum hold time.
// - STOP with watchdog enabled causes a watchdog reset instead.
// - STOP-caused watchdog reset keeps oscillator, no start-up delay.
// - Mask option: count through WAIT, or hold cleared during WAIT.
// - Power-on and external reset preset timer, stack pointer, enables.
// - WAIT and STOP clear the mask bit; resets set it, fetch vector.
// - Power-on and STOP stop oscillator 4064 cycles, clear clocks.
// - All events clear watchdog counter; enable and slow bit except WAIT.
// - Power-on flag only on power-on; resets set interrupt enable, clear latches.
// - Resets disable serial unit and set transmit empty and complete.
// - Interrupt taken after instruction only if unmasked and enabled.
// - Taking sets mask; return restores mask from stack.
// - Power-on pin low time is 16 or 4064 cycles by mask option; the code adds the 4064-cycle oscillator delay first.
// - Software cannot set power-on flag; writing zero clears it.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "rwc_consts.vh"

module rwc_top (
    input wire aclk, // Bus clock, 125 MHz
    input wire aresetn, // Power-on reset, synchronous, active low
    input wire [3:0] awaddr, // Write address
    input wire awvalid, // Write address valid
    output reg awready, // Write address ready
    input wire [31:0] wdata, // Write data
    input wire [3:0] wstrb, // Write byte strobes
    input wire wvalid, // Write data valid
    output reg wready, // Write data ready
    output reg [1:0] bresp, // Write response
    output reg bvalid, // Write response valid
    input wire bready, // Write response ready
    input wire [3:0] araddr, // Read address
    input wire arvalid, // Read address valid
    output reg arready, // Read address ready
    output reg [31:0] rdata, // Read data
    output reg [1:0] rresp, // Read response
    output reg rvalid, // Read data valid
    input wire rready, // Read data ready
    input wire rst_pin_i, // Reset pin level
    output reg rst_pin_o, // Reset pin drive value, always low
    output reg rst_pin_oe, // Reset pin pull-down on
    input wire opt_watchdog_enable_clear_bit_auto, // Mask option: watchdog on after reset
    input wire opt_wait_run, // Mask option: watchdog runs in WAIT
    input wire opt_por_long, // Mask option: long power-on delay
    input wire tmr_bit7_carry, // Timer bit 7 carry pulse
    input wire stop_instr, // STOP executed, pulse
    input wire wait_instr, // WAIT executed, pulse
    input wire wake_evt, // Wake event out of STOP or WAIT, pulse
    input wire instr_done, // Current instruction complete, pulse
    input wire int_pend, // Hardware interrupt pending
    input wire int_en, // Its enable bit
    input wire rti_instr, // Return from interrupt, pulse
    input wire stacked_mask, // Mask bit taken from stack
    input wire sci_tx_load, // Serial unit loads transmit data, pulse
    output reg core_rst_q, // Merged reset to core and peripherals
    output reg osc_off_q, // Oscillator held off
    output reg clk_clear_q, // Timer and serial clocks held clear
    output reg vec_fetch_q, // Fetch reset vector, pulse
    output reg take_int_q, // Interrupt taken, pulse
    output reg next_fetch_q, // Next instruction fetched, pulse
    output reg cond_mask_q, // Interrupt mask bit
    output reg ext_int_en_q, // External interrupt enable bit
    output reg slow_mode_q, // Slow mode bit
    output reg stop_latch_q, // STOP mode active
    output reg wait_latch_q, // WAIT mode active
    output reg tx_data_empty_flag_q, // Serial transmit data empty
    output reg tx_complete_flag_q, // Serial transmit complete
    output reg [15:0] tmr_init_q, // Timer counter load value
    output reg [15:0] sp_init_q // Stack pointer load value
);
    // ****************************************
    // Constants
    // ****************************************
    localparam [31:0] WD_LOW_W = `RWC_WATCHDOG_ENABLE_CLEAR_BIT_LOW_CYC;
    localparam [31:0] EXT_LOW_W = `RWC_EXT_LOW_CYC;
    localparam [7:0] WD_LOW_CYC = WD_LOW_W[7:0];
    localparam [1:0] EXT_LOW_CYC = EXT_LOW_W[1:0];
    localparam [3:0] S_POR = 4'h1;
    localparam [3:0] S_RUN = 4'h2;
    localparam [3:0] S_WDRV = 4'h4;
    localparam [3:0] S_REL = 4'h8;

    // ****************************************
    // Declarations
    // ****************************************
    wire pin_lvl;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [11:0] osc_cnt_q;
    reg [11:0] por_cnt_q;
    reg [7:0] low_cnt_q;
    reg [1:0] ext_cnt_q;
    reg ext_rst_q;
    reg por_kind_q;
    reg wd_kind_q;
    reg ext_kind_q;
    reg por_flag_q;
    reg wd_en_q;
    reg [1:0] div4_q;
    reg [7:0] div256_q;
    reg [2:0] div7_q;
    reg [3:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;
    wire wr_go;
    wire wr_misc;
    wire wd_write1;
    wire wd_fire;
    wire wd_hold;
    wire wd_tick;
    wire stop_to_wd;
    wire rst_d;
    wire [7:0] misc_rd;
    wire [7:0] stat_rd;

    // ****************************************
    // Reset pin input
    // ****************************************
    rwc_sync u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(rst_pin_i),
        .level_q(pin_lvl)
    );

    // ****************************************
    // Reset sequencer
    // ****************************************
    assign stop_to_wd = stop_instr & wd_en_q & ~core_rst_q;
    assign wd_fire = (div7_q == `RWC_DIV7_FINAL) | stop_to_wd;

    always @* begin
        state_d = state_q;
        case (state_q)
            S_POR: begin
                if (osc_cnt_q == 12'h000 && por_cnt_q == 12'h000) begin
                    state_d = S_REL;
                end
            end
            S_RUN: begin
                if (wd_fire) begin
                    state_d = S_WDRV;
                end
            end
            S_WDRV: begin
                // Pin released only after it was seen low long enough
                if (!pin_lvl && low_cnt_q == WD_LOW_CYC - 8'h01) begin
                    state_d = S_REL;
                end
            end
            S_REL: begin
                // An external RC may keep the pin low after release
                if (pin_lvl) begin
                    state_d = S_RUN;
                end
            end
            default: begin
                state_d = S_POR;
            end
        endcase
    end

    // Synced pin high ends an external reset at once, not a cycle later
    assign rst_d = (state_d != S_RUN) | (ext_rst_q & ~pin_lvl);

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_POR;
            osc_cnt_q <= `RWC_OSC_DELAY_CYC;
            por_cnt_q <= 12'h000;
            low_cnt_q <= 8'h00;
            ext_cnt_q <= 2'h0;
            ext_rst_q <= 1'b0;
            rst_pin_o <= 1'b0;
            rst_pin_oe <= 1'b1;
            core_rst_q <= 1'b1;
            vec_fetch_q <= 1'b0;
            por_kind_q <= 1'b1;
            wd_kind_q <= 1'b0;
            ext_kind_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rst_pin_o <= 1'b0;
            rst_pin_oe <= (state_d == S_POR) | (state_d == S_WDRV);
            core_rst_q <= rst_d;
            vec_fetch_q <= core_rst_q & ~rst_d;
            if (osc_cnt_q != 12'h000) begin
                osc_cnt_q <= osc_cnt_q - 12'h001;
            end else if (stop_latch_q && wake_evt) begin
                osc_cnt_q <= `RWC_OSC_DELAY_CYC;
            end
            // Pin delay counts once the oscillator has settled
            if (state_q == S_POR && osc_cnt_q == 12'h001) begin
                por_cnt_q <= opt_por_long ? `RWC_POR_LONG_CYC : `RWC_POR_SHORT_CYC;
            end else if (osc_cnt_q == 12'h000 && por_cnt_q != 12'h000) begin
                por_cnt_q <= por_cnt_q - 12'h001;
            end
            if (state_q == S_WDRV && !pin_lvl) begin
                low_cnt_q <= low_cnt_q + 8'h01;
            end else begin
                low_cnt_q <= 8'h00;
            end
            if (state_q == S_RUN && state_d == S_WDRV) begin
                wd_kind_q <= 1'b1;
                ext_kind_q <= 1'b0;
                por_kind_q <= 1'b0;
            end
            // External reset is only sensed while the pin is not ours
            if (state_q != S_RUN || pin_lvl) begin
                ext_cnt_q <= 2'h0;
                ext_rst_q <= 1'b0;
            end else if (ext_cnt_q != EXT_LOW_CYC) begin
                ext_cnt_q <= ext_cnt_q + 2'h1;
            end else begin
                ext_rst_q <= 1'b1;
                ext_kind_q <= 1'b1;
                wd_kind_q <= 1'b0;
                por_kind_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Effects of reset, WAIT and STOP
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_off_q <= 1'b1;
            clk_clear_q <= 1'b1;
            stop_latch_q <= 1'b0;
            wait_latch_q <= 1'b0;
            cond_mask_q <= 1'b1;
            take_int_q <= 1'b0;
            next_fetch_q <= 1'b0;
            tx_data_empty_flag_q <= 1'b1;
            tx_complete_flag_q <= 1'b1;
            tmr_init_q <= `RWC_TMR_RESET;
            sp_init_q <= `RWC_SP_RESET;
        end else begin
            osc_off_q <= (osc_cnt_q != 12'h000) | stop_latch_q;
            clk_clear_q <= (osc_cnt_q != 12'h000) | stop_latch_q;
            take_int_q <= 1'b0;
            next_fetch_q <= 1'b0;
            tmr_init_q <= `RWC_TMR_RESET;
            sp_init_q <= `RWC_SP_RESET;
            if (core_rst_q) begin
                stop_latch_q <= 1'b0;
                wait_latch_q <= 1'b0;
                cond_mask_q <= 1'b1;
                tx_data_empty_flag_q <= 1'b1;
                tx_complete_flag_q <= 1'b1;
            end else begin
                if (sci_tx_load) begin
                    tx_data_empty_flag_q <= 1'b0;
                    tx_complete_flag_q <= 1'b0;
                end
                if (stop_instr && !wd_en_q) begin
                    stop_latch_q <= 1'b1;
                    cond_mask_q <= 1'b0;
                end else if (wait_instr) begin
                    wait_latch_q <= 1'b1;
                    cond_mask_q <= 1'b0;
                end else if (wake_evt) begin
                    stop_latch_q <= 1'b0;
                    wait_latch_q <= 1'b0;
                end else if (instr_done) begin
                    if (int_pend && int_en && !cond_mask_q) begin
                        take_int_q <= 1'b1;
                        cond_mask_q <= 1'b1;
                    end else begin
                        next_fetch_q <= 1'b1;
                        if (rti_instr) begin
                            cond_mask_q <= stacked_mask;
                        end
                    end
                end
            end
        end
    end

    // ****************************************
    // Watchdog chain
    // ****************************************
    assign wd_hold = core_rst_q | stop_latch_q | (wait_latch_q & ~opt_wait_run);
    assign wd_tick = tmr_bit7_carry & wd_en_q & ~wd_hold;

    always @(posedge aclk) begin
        if (!aresetn || wd_hold || wait_instr || stop_instr) begin
            div4_q <= 2'h0;
            div256_q <= 8'h00;
            div7_q <= 3'h0;
        end else begin
            if (wd_tick) begin
                div4_q <= div4_q + 2'h1;
                if (div4_q == `RWC_DIV4_LAST) begin
                    div256_q <= div256_q + 8'h01;
                end
            end
            if (wd_write1) begin
                div7_q <= 3'h0;
            end else if (wd_tick && div4_q == `RWC_DIV4_LAST
                         && div256_q == `RWC_DIV256_LAST) begin
                div7_q <= div7_q + 3'h1;
            end
        end
    end

    // ****************************************
    // Miscellaneous register
    // ****************************************
    assign wr_go = aw_have_q & w_have_q & ~bvalid;
    assign wr_misc = wr_go & (aw_addr_q == `RWC_ADDR_MISC) & w_strb_q[0];
    assign wd_write1 = wr_misc & w_data_q[`RWC_MISC_WDE];

    always @(posedge aclk) begin
        if (!aresetn) begin
            por_flag_q <= 1'b1;
            wd_en_q <= 1'b0;
            ext_int_en_q <= 1'b1;
            slow_mode_q <= 1'b0;
        end else if (core_rst_q) begin
            if (por_kind_q) begin
                por_flag_q <= 1'b1;
            end
            wd_en_q <= opt_watchdog_enable_clear_bit_auto;
            ext_int_en_q <= 1'b1;
            slow_mode_q <= 1'b0;
        end else begin
            if (stop_instr && !wd_en_q) begin
                slow_mode_q <= 1'b0;
            end else if (wr_misc) begin
                slow_mode_q <= w_data_q[`RWC_MISC_SLOW];
            end
            if (wr_misc && !w_data_q[`RWC_MISC_POR]) begin
                por_flag_q <= 1'b0;
            end
            if (wd_write1) begin
                wd_en_q <= 1'b1;
            end
            // Interrupt options only change while interrupts are masked
            if (wr_misc && cond_mask_q) begin
                ext_int_en_q <= w_data_q[`RWC_MISC_EIE];
            end
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign misc_rd = {por_flag_q, 2'h0, ext_int_en_q, 2'h0, slow_mode_q, wd_en_q};
    assign stat_rd = {ext_kind_q, wd_kind_q, cond_mask_q, wait_latch_q, stop_latch_q, div7_q};

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RWC_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RWC_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr_q <= awaddr;
                aw_have_q <= 1'b1;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                // Status register is read-only; writing it is an error
                bresp <= (aw_addr_q == `RWC_ADDR_MISC) ? `RWC_RESP_OKAY : `RWC_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= `RWC_RESP_OKAY;
                if (araddr == `RWC_ADDR_MISC) begin
                    rdata <= {24'h000000, misc_rd};
                end else if (araddr == `RWC_ADDR_STAT) begin
                    rdata <= {24'h000000, stat_rd};
                end else begin
                    rdata <= 32'h00000000;
                    rresp <= `RWC_RESP_SLVERR;
                end
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule // rwc_top

// [sim/rwc_checker.sv]
`timescale 1ns/1ps
module rwc_checker (
    input wire aclk, // Clock
    input wire aresetn, // Reset
    input wire instr_done, // In
    input wire rti_instr, // In
    input wire stop_instr, // In
    input wire wait_instr, // In
    input wire wake_evt, // In
    input wire int_pend, // In
    input wire int_en, // In
    input wire stacked_mask, // In
    input wire rst_pin_o, // Out
    input wire rst_pin_oe, // Out
    input wire core_rst_q, // Out
    input wire vec_fetch_q, // Out
    input wire take_int_q, // Out
    input wire next_fetch_q, // Out
    input wire cond_mask_q, // Out
    input wire ext_int_en_q, // Out
    input wire stop_latch_q, // Out
    input wire wait_latch_q, // Out
    input wire tx_data_empty_flag_q, // Out
    input wire tx_complete_flag_q // Out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Strobes only count when no reset or mode change competes
    wire go = !core_rst_q && !stop_instr && !wait_instr && !wake_evt;
    wire want = int_pend && int_en && !cond_mask_q;
    property p_drive; rst_pin_oe |-> !rst_pin_o; endproperty
    a_drive: assert property (p_drive) else $error("reset pin driven high");
    property p_take; instr_done && go && want |=> take_int_q && cond_mask_q; endproperty
    a_take: assert property (p_take) else $error("interrupt not taken");
    property p_fetch; instr_done && go && !want |=> next_fetch_q && !take_int_q; endproperty
    a_fetch: assert property (p_fetch) else $error("next fetch missing");
    property p_rti;
        instr_done && rti_instr && go && !want |=> cond_mask_q == $past(stacked_mask);
    endproperty
    a_rti: assert property (p_rti) else $error("mask not restored");
    property p_wait; wait_instr && !core_rst_q && !wake_evt |=> !cond_mask_q; endproperty
    a_wait: assert property (p_wait) else $error("mask not cleared on wait");
    property p_hold;
        core_rst_q [*2] |-> cond_mask_q && ext_int_en_q && !stop_latch_q && !wait_latch_q;
    endproperty
    a_hold: assert property (p_hold) else $error("reset state wrong");
    property p_sci;
        core_rst_q && $past(core_rst_q) |-> tx_data_empty_flag_q && tx_complete_flag_q;
    endproperty
    a_sci: assert property (p_sci) else $error("serial flags not set");
    property p_vec; $fell(core_rst_q) |-> ##[0:1] vec_fetch_q; endproperty
    a_vec: assert property (p_vec) else $error("vector fetch missing");
    c_take: cover property (take_int_q);
    c_vec: cover property ($fell(core_rst_q));
    c_oe: cover property ($rose(rst_pin_oe));
endmodule // rwc_checker
bind rwc_top rwc_checker u_chk (.*);

// [sim/rwc_pin_model.sv]
`timescale 1ns/1ps
module rwc_pin_model (
    input wire drv_oe, // Device pull-down on
    input wire drv_o, // Device drive value
    input wire ext_low, // Board reset switch closed
    output wire pin // Pin level
);
    // Pull-up wins only when nobody pulls down
    assign pin = !((drv_oe && !drv_o) || ext_low);
endmodule // rwc_pin_model

// [sim/tb_reset_and_watchdog_control.sv]
`timescale 1ns/1ps
module tb_reset_and_watchdog_control;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rd;
    logic [1:0] rsp;
    logic [6:0] ev = 7'h0;
    logic int_pend = 1'h0, int_en = 1'h0, ext_low = 1'h0, opt_a = 1'h0, opt_l = 1'h0;
    wire awready, wready, bvalid, arready, rvalid, pin, rst_pin_o, rst_pin_oe, txe, txc;
    wire core_rst_q, osc_off_q, clk_clear_q, take_int_q, next_fetch_q, cond_mask_q;
    wire ext_int_en_q, slow_mode_q, stop_latch_q, wait_latch_q;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] tmr, sp;
    wire [2:0] mon = {osc_off_q, rst_pin_oe, core_rst_q};
    wire [7:0] st = {cond_mask_q, ext_int_en_q, txe, txc, stop_latch_q, wait_latch_q,
        slow_mode_q, osc_off_q};
    int fails = 0, total_checks = 0, n;
    rwc_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .rst_pin_i(pin), .rst_pin_o, .rst_pin_oe,
        .opt_watchdog_enable_clear_bit_auto(opt_a), .opt_wait_run(1'h0), .opt_por_long(opt_l),
        .tmr_bit7_carry(ev[6]), .stop_instr(ev[0]), .wait_instr(ev[1]), .wake_evt(ev[2]),
        .instr_done(ev[3]), .int_pend, .int_en, .rti_instr(ev[4]), .stacked_mask(1'h0),
        .sci_tx_load(ev[5]), .core_rst_q, .osc_off_q, .clk_clear_q, .vec_fetch_q(),
        .take_int_q, .next_fetch_q, .cond_mask_q, .ext_int_en_q, .slow_mode_q, .stop_latch_q,
        .wait_latch_q, .tx_data_empty_flag_q(txe), .tx_complete_flag_q(txc),
        .tmr_init_q(tmr), .sp_init_q(sp));
    rwc_pin_model pm_u (.drv_oe(rst_pin_oe), .drv_o(rst_pin_o), .ext_low, .pin);
    initial forever #4 aclk = ~aclk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One bus access; each channel drops valid only at its own handshake
    task automatic ax(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (arready) arvalid <= 1'h0;
        end while (!(wr ? bvalid : rvalid));
        {rsp, rd} = wr ? {bresp, 32'h0} : {rresp, rdata};
        {bready, rready} <= 2'h0;
    endtask
    // One-cycle strobe; results are sampled mid-cycle, after the design's edge
    task automatic strobe(input logic [6:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 7'h0;
        @(negedge aclk);
    endtask
    task automatic wt(input int b, input logic v);
        n = 0;
        while (mon[b] !== v && n < 9000) begin
            @(negedge aclk);
            n++;
        end
        if (n >= 9000) chk("wait limit", 32'h0, 32'h1);
    endtask
    initial begin
        repeat (80000) @(posedge aclk);
        fails++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        wt(0, 1'h0);
        chk("por cycles", 1, n >= 4080 && n <= 4100);
        chk("timer", 32'hfffc, tmr);
        chk("stack", 32'h00ff, sp);
        chk("state", 32'hf0, st);
        ax(1'h0, 4'h0, 32'h0);
        chk("misc", 32'h90, rd);
        ax(1'h1, 4'h0, 32'h90);
        ax(1'h0, 4'h0, 32'h0);
        chk("por keep", 32'h90, rd);
        ax(1'h1, 4'h0, 32'h10);
        ax(1'h0, 4'h0, 32'h0);
        chk("por clear", 32'h10, rd);
        ax(1'h0, 4'h8, 32'h0);
        chk("unmapped", 32'h2, rsp);
        ax(1'h1, 4'h4, 32'h0);
        chk("ro write", 32'h2, rsp);
        int_pend <= 1'h1;
        int_en <= 1'h1;
        strobe(7'h08);
        chk("masked", 32'h1, {take_int_q, next_fetch_q});
        strobe(7'h02);
        chk("wait", 32'h1, {cond_mask_q, wait_latch_q});
        strobe(7'h04);
        strobe(7'h08);
        chk("taken", 32'h5, {take_int_q, next_fetch_q, cond_mask_q});
        int_pend <= 1'h0;
        strobe(7'h18);
        chk("rti", 32'h1, {cond_mask_q, next_fetch_q});
        int_pend <= 1'h1;
        int_en <= 1'h0;
        strobe(7'h08);
        chk("disabled", 32'h1, {take_int_q, next_fetch_q});
        strobe(7'h20);
        chk("tx load", 32'h0, {txe, txc});
        ax(1'h1, 4'h0, 32'h11);
        ax(1'h1, 4'h0, 32'h10);
        ax(1'h0, 4'h0, 32'h0);
        chk("watchdog_enable_clear_bit on", 32'h1, rd[0]);
        repeat (3000) strobe(7'h40);
        ax(1'h1, 4'h0, 32'h11);
        ax(1'h0, 4'h4, 32'h0);
        chk("count clear", 32'h0, rd[2:0]);
        n = 0;
        while (core_rst_q !== 1'h1 && n < 8000) begin
            strobe(7'h40);
            n++;
        end
        // Prescalers keep their phase across a clear, so only a window is known
        chk("watchdog_enable_clear_bit period", 1, n > 6144 && n <= 7169);
        wt(1, 1'h0);
        chk("pin low", 1, n >= 120 && n < 140);
        wt(0, 1'h0);
        ax(1'h0, 4'h0, 32'h0);
        chk("after watchdog_enable_clear_bit", 32'h10, rd);
        chk("state watchdog_enable_clear_bit", 32'hf0, st);
        ax(1'h1, 4'h0, 32'h11);
        strobe(7'h01);
        wt(0, 1'h1);
        chk("stop reset", 1, n < 4 && osc_off_q === 1'h0);
        wt(0, 1'h0);
        ax(1'h0, 4'h0, 32'h0);
        chk("stop after", 32'h10, rd);
        ext_low <= 1'h1;
        @(posedge aclk);
        ext_low <= 1'h0;
        repeat (6) @(posedge aclk);
        chk("glitch", 32'h0, core_rst_q);
        ext_low <= 1'h1;
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        chk("ext hold", 32'h2, {core_rst_q, rst_pin_oe});
        @(posedge aclk);
        ext_low <= 1'h0;
        wt(0, 1'h0);
        chk("resume", 1, n <= 6);
        strobe(7'h01);
        @(negedge aclk);
        chk("stop", 32'hb, {stop_latch_q, cond_mask_q, osc_off_q, clk_clear_q});
        strobe(7'h04);
        wt(2, 1'h0);
        chk("osc delay", 1, n >= 4058 && n <= 4070);
        @(posedge aclk);
        {opt_a, opt_l, aresetn} <= 3'h6;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        wt(0, 1'h0);
        chk("long por", 1, n >= 8128 && n <= 8150);
        ax(1'h0, 4'h0, 32'h0);
        chk("auto watchdog_enable_clear_bit", 32'h91, rd);
        print_verdict;
    end
endmodule // tb_reset_and_watchdog_control
